// [verification/remote_uart.sv]
// Purpose: remote serial sender feeding the core receive line
// Assumes: divisor 1, so one bit lasts 16 clocks
// Notes: idles high like a pulled-up line
`timescale 1ns/1ps
module remote_uart (
  input wire logic clk_i,
  output logic line_o
);
  initial line_o = 1'b1;
  // start low, data lsb first, ninth bit when asked, one stop
  task automatic send(input logic [8:0] d, input logic nine);
    logic [10:0] f;
    f = nine ? {1'b1, d, 1'b0} : {2'b11, d[7:0], 1'b0};
    for (int i = 0; i < (nine ? 11 : 10); i++) begin
      @(posedge clk_i);
      line_o <= f[i];
      repeat (15) @(posedge clk_i);
    end
    #1;
  endtask
endmodule

// [verification/tb_uart_serial_port_core.sv]
// Purpose: self-checking bench for the serial port core
// Assumes: register port with read data one cycle after the strobe
// Notes: infrared receive and dma acks stay idle, so their paths go untested
`timescale 1ns/1ps
module tb_uart_serial_port_core import uart_core_pkg::*;;
  logic ref_clk, rst_n, wr, rd, cts_n, rxd, txd, irtx, rts_n, dmarx, dmatx, irq;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, d;
  int errors = 0;
  int total_checks = 0;
  int n, lo;
  uart_serial_port_core u_dut (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .rxd_i(rxd), .txd_o(txd), .ir_rx_n_i(1'b1), .ir_tx_o(irtx),
    .cts_n_i(cts_n), .rts_n_o(rts_n), .dma_rx_ack_i(1'b0), .dma_tx_ack_i(1'b0), .dma_rx_req_o(dmarx),
    .dma_tx_req_o(dmatx), .modem_irq_o(irq));
  remote_uart u_rem (.clk_i(ref_clk), .line_o(rxd));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a);
    @(posedge ref_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // bounded wait; a hang ends the run
  task automatic wait_txd(input logic v);
    for (int i = 0; i < 400; i++) begin
      @(posedge ref_clk);
      #1;
      if (txd === v) return;
    end
    errors++;
    complete_run();
  endtask
  // samples each bit at its middle, blen clocks a bit
  task automatic txchk(input logic [7:0] v, input int blen);
    wreg(ADDR_DATA, {24'h0, v});
    wait_txd(1'b0);
    repeat (blen / 2) @(posedge ref_clk);
    for (int i = 0; i < 10; i++) begin
      #1 chk(txd, (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : v[i-1]);
      repeat (blen) @(posedge ref_clk);
    end
  endtask
  task automatic t_reset();
    rreg(ADDR_FIFO);
    chk(d, 32'h0000_0020);
    rreg(8'h18);
    chk(d, 32'h0);
    rreg(ADDR_MODEM);
    chk(d, 32'h1);
  endtask
  task automatic t_tx();
    wreg(ADDR_DIV, 32'h2);
    txchk(8'h55, 32);
    wreg(ADDR_DIV, 32'h0);
    txchk(8'hc6, 16);
    wreg(ADDR_DIV, 32'h8_0001);
    txchk(8'h3a, 24);
    wreg(ADDR_DIV, 32'h1);
  endtask
  task automatic t_irda();
    wreg(ADDR_LINE, 32'h41);
    wreg(ADDR_DATA, 32'h10f);
    n = 0;
    lo = 0;
    repeat (220) begin
      @(posedge ref_clk);
      #1 n += irtx;
      lo += !txd;
    end
    chk(n, 15);
    chk(lo, 0);
    wreg(ADDR_LINE, 32'h0);
  endtask
  task automatic t_rx();
    u_rem.send(9'h0a5, 1'b0);
    rreg(ADDR_DATA);
    chk(d, 32'ha5);
    wreg(ADDR_LINE, 32'h3c30);
    u_rem.send(9'h13c, 1'b1);
    u_rem.send(9'h011, 1'b1);
    u_rem.send(9'h155, 1'b1);
    u_rem.send(9'h022, 1'b1);
    rreg(ADDR_DATA);
    chk(d, 32'h011);
    rreg(ADDR_DATA);
    chk(d, 32'h0);
    wreg(ADDR_LINE, 32'h0);
  endtask
  task automatic t_flow();
    wreg(ADDR_FIFO, 32'h0a);
    #20 chk(dmatx, 0);
    wreg(ADDR_FIFO, 32'h0b);
    wreg(ADDR_MODEM, 32'h2);
    #20 chk(dmatx, 1);
    u_rem.send(9'h031, 1'b0);
    chk(rts_n, 0);
    u_rem.send(9'h032, 1'b0);
    chk(rts_n, 1);
    chk(dmarx, 1);
    u_rem.send(9'h033, 1'b0);
    rreg(ADDR_MODEM);
    chk(d, 32'h3);
    rreg(ADDR_DATA);
    #30 chk(rts_n, 1);
    rreg(ADDR_DATA);
    chk(d, 32'h032);
    #30 chk(rts_n, 0);
    rreg(ADDR_DATA);
    chk(d, 32'h033);
    #30 chk(rts_n, 0);
    @(posedge ref_clk);
    cts_n <= 1'b1;
    wreg(ADDR_DATA, 32'h5a);
    lo = 0;
    repeat (40) begin
      @(posedge ref_clk);
      #1 lo += !txd;
    end
    chk(lo, 0);
    rreg(ADDR_STAT);
    chk(d[0], 1);
    chk(irq, 0);
    @(posedge ref_clk);
    cts_n <= 1'b0;
    wait_txd(1'b0);
    repeat (170) @(posedge ref_clk);
  endtask
  initial begin
    rst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    cts_n = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset();
    t_tx();
    t_irda();
    t_rx();
    t_flow();
    complete_run();
  end
endmodule

// [verilog/baud_tick_gen.sv]
// Purpose: sixteen-times oversampling tick with fractional divisor
// Assumes: divisor fields held stable by software while the line is busy
// Notes: one-cycle tick, average period divisor plus fraction/16 clocks
`timescale 1ns/1ps
module baud_tick_gen import uart_core_pkg::*; (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [15:0] div_int_i,
  input wire logic [3:0] div_frac_i,
  output logic tick_o
);
  logic [15:0] cnt_reg;
  logic [3:0] acc_reg;
  logic [4:0] acc_sum;
  logic [15:0] div_eff;

  assign div_eff = (div_int_i == DIV_ZERO) ? DIV_ONE : div_int_i;
  assign acc_sum = {1'b0, acc_reg} + {1'b0, div_frac_i};

  // carry of the accumulator stretches one tick by a clock
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg <= 16'h0000;
      acc_reg <= 4'h0;
      tick_o <= 1'b0;
    end else if (cnt_reg == 16'h0000) begin
      tick_o <= 1'b1;
      acc_reg <= acc_sum[3:0];
      cnt_reg <= div_eff - DIV_ONE + {15'h0000, acc_sum[4]};
    end else begin
      tick_o <= 1'b0;
      cnt_reg <= cnt_reg - DIV_ONE;
    end
  end

  tick_spacing_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    tick_o |=> !tick_o || $past(div_eff == DIV_ONE && acc_sum[4] == 1'b0, 2))
    else $error("tick repeated faster than divisor allows");
endmodule

// [verilog/uart_core_pkg.sv]
// Purpose: shared constants and types for the serial port core
// Assumes: one 100 MHz clock, plain register port with 32-bit data
// Notes: register offsets are byte addresses, one word each
package uart_core_pkg;
  localparam logic [7:0] ADDR_DATA = 8'h00;
  localparam logic [7:0] ADDR_DIV = 8'h04;
  localparam logic [7:0] ADDR_LINE = 8'h08;
  localparam logic [7:0] ADDR_FIFO = 8'h0c;
  localparam logic [7:0] ADDR_MODEM = 8'h10;
  localparam logic [7:0] ADDR_STAT = 8'h14;
  // line control fields
  localparam int LC_PAR_EN = 0;
  localparam int LC_PAR_ODD = 1;
  localparam int LC_STOP_LO = 2;
  localparam int LC_NINE = 4;
  localparam int LC_HW_MATCH = 5;
  localparam int LC_IRDA = 6;
  localparam int LC_ADDR_LO = 8;
  // fifo control fields
  localparam int FC_FIFO_EN = 0;
  localparam int FC_DMA = 1;
  localparam int FC_TRIG_LO = 2;
  // modem control fields, then the divisor fraction position
  localparam int MC_RTS = 0;
  localparam int MC_AUTO_FLOW_ENABLE = 1;
  localparam int MC_CTS_IE = 2;
  localparam int DIV_FRAC_LO = 16;
  // reset values and divisor limits
  localparam logic [15:0] DIV_RESET = 16'h0001;
  localparam logic [3:0] TRIG_RESET = 4'h8;
  localparam logic [7:0] OWN_ADDR_RESET = 8'h00;
  localparam logic [15:0] DIV_ZERO = 16'h0000;
  localparam logic [15:0] DIV_ONE = 16'h0001;
  // sixteenth-bit tick counts, last bit indices, fifo depth
  localparam logic [4:0] BIT_LAST = 5'h0f;
  localparam logic [4:0] MID_TICK = 5'h07;
  localparam logic [4:0] STOP15_LAST = 5'h17;
  localparam logic [4:0] STOP2_LAST = 5'h1f;
  localparam logic [4:0] IR_PULSE_TICKS = 5'h03;
  localparam logic [4:0] IR_STRETCH = 5'h0c;
  localparam logic [3:0] LAST_BIT8 = 4'h7;
  localparam logic [3:0] LAST_BIT9 = 4'h8;
  localparam logic [9:0] TIMEOUT_TICKS = 10'h280;
  localparam logic [4:0] FIFO_DEPTH = 5'h10;
  typedef enum logic [1:0] {STOP_1 = 2'b00, STOP_1P5 = 2'b01, STOP_2 = 2'b10} stop_sel_t;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000, S_START = 3'b001, S_DATA = 3'b010, S_PAR = 3'b011, S_STOP = 3'b100
  } ser_state_t;
endpackage

// [verilog/uart_serial_port_core.sv]
// Purpose: serial transceiver with 9-bit addressing, IrDA SIR, flow control, DMA requests
// Assumes: register port strobes one cycle, read data valid the cycle after
// Notes: sixteen-deep flip-flop FIFOs each way
// Contract
// - frame goes start bit, data bits, optional parity, then stop bits.
// - stop length one, one and half or two bits; parity optional.
// - nine-bit mode puts ninth bit after bit eight, before parity and stop.
// - ninth bit one marks an address, zero marks data.
// - slave keeps data after own address, drops data after other addresses.
// - address matching done by hardware or left to software.
// - bit rate is clock over sixteen times the sixteen-bit divisor.
// - four-bit fraction adds n sixteenths to the divisor.
// - infrared frames are one start, eight data, one stop, no parity.
// - infrared sends a pulse for every zero bit, none for ones.
// - infrared pulse lasts three sixteenths of a bit.
// - infrared receive input has opposite polarity to transmitted pulses.
// - automatic flow drives RTS high when receive level reaches trigger.
// - automatic flow drives RTS low again once level falls below trigger.
// - receiver accepts one more character after RTS goes high.
// - manual RTS follows control bit; automatic mirrors pin into read-only bit.
// - automatic CTS starts a character only while CTS is low.
// - CTS change always sets delta flag; interrupt needs enable in auto mode.
// - DMA mode bit works only while FIFO enable is set.
// - receive DMA request on level at or over trigger or timeout; controller clears.
// - transmit DMA request while transmit FIFO not full; controller clears.
// - a zero integer divisor acts as one.
// - data bits leave least significant first.
`timescale 1ns/1ps
module uart_serial_port_core import uart_core_pkg::*; (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic rxd_i,
  output logic txd_o,
  input wire logic ir_rx_n_i,
  output logic ir_tx_o,
  input wire logic cts_n_i,
  output logic rts_n_o,
  input wire logic dma_rx_ack_i,
  input wire logic dma_tx_ack_i,
  output logic dma_rx_req_o,
  output logic dma_tx_req_o,
  output logic modem_irq_o
);
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  logic [15:0] div_int_reg;
  logic [3:0] div_frac_reg;
  logic par_en_reg, par_odd_reg, nine_reg, hw_match_reg, irda_reg;
  stop_sel_t stop_reg;
  logic [7:0] own_addr_reg;
  logic fifo_en_reg, dma_mode_reg, dma_en;
  logic [3:0] rx_trig_reg;
  logic rts_bit_reg, auto_flow_enable_reg, cts_ie_reg;
  logic tick;
  logic [8:0] tx_mem [16];
  logic [8:0] rx_mem [16];
  logic [3:0] tx_wp_reg, tx_rp_reg, rx_wp_reg, rx_rp_reg;
  logic [4:0] tx_cnt_reg, rx_cnt_reg;
  logic tx_push, tx_pop, rx_push, rx_pop;
  ser_state_t tx_state_reg, rx_state_reg;
  logic [8:0] tx_shift_reg, rx_shift_reg, rx_word;
  logic [3:0] tx_bit_reg, rx_bit_reg, last_bit;
  logic [4:0] tx_tick_reg, rx_tick_reg, stop_last, ir_cnt_reg;
  logic tx_par_reg, tx_line, rx_line, rx_prev_reg, rx_par_reg;
  logic rx_done_reg, rx_ferr_reg, rx_perr;
  logic match_reg, perr_reg, ferr_reg, ovr_reg, delta_cts_reg, cts_prev_reg;
  logic [9:0] to_cnt_reg;
  logic timeout, at_trig;

  baud_tick_gen u_baud (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .div_int_i(div_int_reg),
    .div_frac_i(div_frac_reg),
    .tick_o(tick)
  );

  assign dma_en = fifo_en_reg & dma_mode_reg;
  assign at_trig = rx_cnt_reg >= {1'b0, rx_trig_reg};
  // infrared forces eight data bits, no parity, one stop
  assign last_bit = (nine_reg && !irda_reg) ? LAST_BIT9 : LAST_BIT8;
  assign stop_last = irda_reg ? BIT_LAST : (stop_reg == STOP_1P5) ? STOP15_LAST :
                     (stop_reg == STOP_2) ? STOP2_LAST : BIT_LAST;

  // control registers
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_int_reg <= DIV_RESET;
      div_frac_reg <= 4'h0;
      par_en_reg <= 1'b0;
      par_odd_reg <= 1'b0;
      stop_reg <= STOP_1;
      nine_reg <= 1'b0;
      hw_match_reg <= 1'b0;
      irda_reg <= 1'b0;
      own_addr_reg <= OWN_ADDR_RESET;
      fifo_en_reg <= 1'b0;
      dma_mode_reg <= 1'b0;
      rx_trig_reg <= TRIG_RESET;
      auto_flow_enable_reg <= 1'b0;
      cts_ie_reg <= 1'b0;
    end else if (wr_i) begin
      if (hit(addr_i, ADDR_DIV)) begin
        div_int_reg <= wdata_i[15:0];
        div_frac_reg <= wdata_i[DIV_FRAC_LO +: 4];
      end else if (hit(addr_i, ADDR_LINE)) begin
        par_en_reg <= wdata_i[LC_PAR_EN];
        par_odd_reg <= wdata_i[LC_PAR_ODD];
        stop_reg <= stop_sel_t'(wdata_i[LC_STOP_LO +: 2]);
        nine_reg <= wdata_i[LC_NINE];
        hw_match_reg <= wdata_i[LC_HW_MATCH];
        irda_reg <= wdata_i[LC_IRDA];
        own_addr_reg <= wdata_i[LC_ADDR_LO +: 8];
      end else if (hit(addr_i, ADDR_FIFO)) begin
        fifo_en_reg <= wdata_i[FC_FIFO_EN];
        dma_mode_reg <= wdata_i[FC_DMA];
        rx_trig_reg <= wdata_i[FC_TRIG_LO +: 4];
      end else if (hit(addr_i, ADDR_MODEM)) begin
        auto_flow_enable_reg <= wdata_i[MC_AUTO_FLOW_ENABLE];
        cts_ie_reg <= wdata_i[MC_CTS_IE];
      end
    end
  end

  // software owns the bit only without automatic flow
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rts_bit_reg <= 1'b1;
    end else if (auto_flow_enable_reg) begin
      rts_bit_reg <= rts_n_o;
    end else if (wr_i && hit(addr_i, ADDR_MODEM)) begin
      rts_bit_reg <= wdata_i[MC_RTS];
    end
  end

  // automatic flow: high at trigger, low below it, else follows the bit; the spare slots above trigger take the late character
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rts_n_o <= 1'b1;
    end else begin
      rts_n_o <= auto_flow_enable_reg ? at_trig : rts_bit_reg;
    end
  end

  // transmit fifo
  assign tx_push = wr_i && hit(addr_i, ADDR_DATA) && tx_cnt_reg != FIFO_DEPTH;
  // with automatic flow, a character starts only while clear to send
  assign tx_pop = tx_state_reg == S_IDLE && tx_cnt_reg != 5'h00 && (!auto_flow_enable_reg || !cts_n_i);
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_wp_reg <= 4'h0;
      tx_rp_reg <= 4'h0;
      tx_cnt_reg <= 5'h00;
    end else begin
      if (tx_push) begin
        tx_mem[tx_wp_reg] <= wdata_i[8:0];
        tx_wp_reg <= tx_wp_reg + 4'h1;
      end
      if (tx_pop) begin
        tx_rp_reg <= tx_rp_reg + 4'h1;
      end
      tx_cnt_reg <= tx_cnt_reg + {4'h0, tx_push} - {4'h0, tx_pop};
    end
  end

  // transmitter
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_state_reg <= S_IDLE;
      tx_shift_reg <= 9'h000;
      tx_bit_reg <= 4'h0;
      tx_tick_reg <= 5'h00;
      tx_par_reg <= 1'b0;
    end else if (tx_pop) begin
      tx_shift_reg <= (last_bit == LAST_BIT9) ? tx_mem[tx_rp_reg] : {1'b0, tx_mem[tx_rp_reg][7:0]};
      tx_par_reg <= ^((last_bit == LAST_BIT9) ? tx_mem[tx_rp_reg] : {1'b0, tx_mem[tx_rp_reg][7:0]});
      tx_tick_reg <= 5'h00;
      tx_bit_reg <= 4'h0;
      tx_state_reg <= S_START;
    end else if (tick && tx_state_reg != S_IDLE) begin
      tx_tick_reg <= tx_tick_reg + 5'h01;
      case (tx_state_reg)
        S_START: begin
          if (tx_tick_reg == BIT_LAST) begin
            tx_tick_reg <= 5'h00;
            tx_state_reg <= S_DATA;
          end
        end
        S_DATA: begin
          if (tx_tick_reg == BIT_LAST) begin
            tx_tick_reg <= 5'h00;
            tx_shift_reg <= {1'b0, tx_shift_reg[8:1]};
            tx_bit_reg <= tx_bit_reg + 4'h1;
            if (tx_bit_reg == last_bit) begin
              tx_state_reg <= (par_en_reg && !irda_reg) ? S_PAR : S_STOP;
            end
          end
        end
        S_PAR: begin
          if (tx_tick_reg == BIT_LAST) begin
            tx_tick_reg <= 5'h00;
            tx_state_reg <= S_STOP;
          end
        end
        default: begin
          if (tx_tick_reg == stop_last) begin
            tx_state_reg <= S_IDLE;
          end
        end
      endcase
    end
  end

  always_comb begin
    case (tx_state_reg)
      S_START: tx_line = 1'b0;
      S_DATA: tx_line = tx_shift_reg[0];
      S_PAR: tx_line = tx_par_reg ^ par_odd_reg;
      default: tx_line = 1'b1;
    endcase
  end

  // infrared mode parks the wired line and pulses on zeros
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      txd_o <= 1'b1;
      ir_tx_o <= 1'b0;
    end else begin
      txd_o <= irda_reg ? 1'b1 : tx_line;
      ir_tx_o <= irda_reg && !tx_line && tx_tick_reg < IR_PULSE_TICKS;
    end
  end

  // receive pulses arrive low; stretched to cover the bit midpoint
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ir_cnt_reg <= 5'h00;
    end else if (!ir_rx_n_i) begin
      ir_cnt_reg <= IR_STRETCH;
    end else if (tick && ir_cnt_reg != 5'h00) begin
      ir_cnt_reg <= ir_cnt_reg - 5'h01;
    end
  end
  assign rx_line = irda_reg ? (ir_rx_n_i && ir_cnt_reg == 5'h00) : rxd_i;
  assign rx_word = (last_bit == LAST_BIT9) ? rx_shift_reg : {1'b0, rx_shift_reg[8:1]};
  assign rx_perr = par_en_reg && !irda_reg && (rx_par_reg != (^rx_word ^ par_odd_reg));

  // receiver
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_state_reg <= S_IDLE;
      rx_prev_reg <= 1'b1;
      rx_shift_reg <= 9'h000;
      rx_bit_reg <= 4'h0;
      rx_tick_reg <= 5'h00;
      rx_par_reg <= 1'b0;
      rx_done_reg <= 1'b0;
      rx_ferr_reg <= 1'b0;
    end else begin
      rx_prev_reg <= rx_line;
      rx_done_reg <= 1'b0;
      if (rx_state_reg == S_IDLE) begin
        if (rx_prev_reg && !rx_line) begin
          rx_state_reg <= S_START;
          rx_tick_reg <= 5'h00;
        end
      end else if (tick) begin
        rx_tick_reg <= rx_tick_reg + 5'h01;
        case (rx_state_reg)
          S_START: begin
            if (rx_tick_reg == MID_TICK) begin
              rx_tick_reg <= 5'h00;
              rx_bit_reg <= 4'h0;
              rx_state_reg <= rx_line ? S_IDLE : S_DATA;
            end
          end
          S_DATA: begin
            if (rx_tick_reg == BIT_LAST) begin
              rx_tick_reg <= 5'h00;
              rx_shift_reg <= {rx_line, rx_shift_reg[8:1]};
              rx_bit_reg <= rx_bit_reg + 4'h1;
              if (rx_bit_reg == last_bit) begin
                rx_state_reg <= (par_en_reg && !irda_reg) ? S_PAR : S_STOP;
              end
            end
          end
          S_PAR: begin
            if (rx_tick_reg == BIT_LAST) begin
              rx_tick_reg <= 5'h00;
              rx_par_reg <= rx_line;
              rx_state_reg <= S_STOP;
            end
          end
          default: begin
            if (rx_tick_reg == BIT_LAST) begin
              rx_ferr_reg <= !rx_line;
              rx_done_reg <= 1'b1;
              rx_state_reg <= S_IDLE;
            end
          end
        endcase
      end
    end
  end

  // hardware match hides addresses and unselected data; software mode keeps all
  assign rx_push = rx_done_reg && !(nine_reg && hw_match_reg && (rx_word[8] || !match_reg));
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      match_reg <= 1'b0;
    end else if (rx_done_reg && nine_reg && rx_word[8]) begin
      match_reg <= rx_word[7:0] == own_addr_reg;
    end
  end

  // receive fifo, overflow drops the new character
  assign rx_pop = rd_i && hit(addr_i, ADDR_DATA) && rx_cnt_reg != 5'h00;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_wp_reg <= 4'h0;
      rx_rp_reg <= 4'h0;
      rx_cnt_reg <= 5'h00;
    end else begin
      if (rx_push && rx_cnt_reg != FIFO_DEPTH) begin
        rx_mem[rx_wp_reg] <= rx_word;
        rx_wp_reg <= rx_wp_reg + 4'h1;
      end
      if (rx_pop) begin
        rx_rp_reg <= rx_rp_reg + 4'h1;
      end
      rx_cnt_reg <= rx_cnt_reg + {4'h0, rx_push && rx_cnt_reg != FIFO_DEPTH} - {4'h0, rx_pop};
    end
  end

  // sticky status, set beats the clear-on-read
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      perr_reg <= 1'b0;
      ferr_reg <= 1'b0;
      ovr_reg <= 1'b0;
      delta_cts_reg <= 1'b0;
      cts_prev_reg <= 1'b1;
    end else begin
      cts_prev_reg <= cts_n_i;
      if (rd_i && hit(addr_i, ADDR_STAT)) begin
        perr_reg <= 1'b0;
        ferr_reg <= 1'b0;
        ovr_reg <= 1'b0;
        delta_cts_reg <= 1'b0;
      end
      if (rx_push && rx_perr) perr_reg <= 1'b1;
      if (rx_push && rx_ferr_reg) ferr_reg <= 1'b1;
      if (rx_push && rx_cnt_reg == FIFO_DEPTH) ovr_reg <= 1'b1;
      if (cts_n_i != cts_prev_reg) delta_cts_reg <= 1'b1;
    end
  end

  // idle time with data waiting, in sixteenth-bit ticks
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      to_cnt_reg <= 10'h000;
    end else if (rx_cnt_reg == 5'h00 || rx_state_reg != S_IDLE || rx_pop) begin
      to_cnt_reg <= 10'h000;
    end else if (tick && !timeout) begin
      to_cnt_reg <= to_cnt_reg + 10'h001;
    end
  end
  assign timeout = to_cnt_reg == TIMEOUT_TICKS;

  // requests: set wins over the controller's clear
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dma_rx_req_o <= 1'b0;
      dma_tx_req_o <= 1'b0;
      modem_irq_o <= 1'b0;
    end else begin
      if (!dma_en) dma_rx_req_o <= 1'b0;
      else if (at_trig || timeout) dma_rx_req_o <= 1'b1;
      else if (dma_rx_ack_i) dma_rx_req_o <= 1'b0;
      if (!dma_en) dma_tx_req_o <= 1'b0;
      else if (tx_cnt_reg != FIFO_DEPTH) dma_tx_req_o <= 1'b1;
      else if (dma_tx_ack_i) dma_tx_req_o <= 1'b0;
      modem_irq_o <= delta_cts_reg && (!auto_flow_enable_reg || cts_ie_reg);
    end
  end

  // read port, data the cycle after the strobe only
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= 32'h0000_0000;
    end else begin
      rdata_o <= 32'h0000_0000;
      if (rd_i) begin
        if (rx_pop) rdata_o <= {23'h000000, rx_mem[rx_rp_reg]};
        else if (hit(addr_i, ADDR_DIV)) rdata_o <= {12'h000, div_frac_reg, div_int_reg};
        else if (hit(addr_i, ADDR_LINE)) rdata_o <= {16'h0000, own_addr_reg, 1'b0, irda_reg,
                                                     hw_match_reg, nine_reg, stop_reg, par_odd_reg, par_en_reg};
        else if (hit(addr_i, ADDR_FIFO)) rdata_o <= {26'h0000000, rx_trig_reg, dma_mode_reg, fifo_en_reg};
        else if (hit(addr_i, ADDR_MODEM)) rdata_o <= {29'h00000000, cts_ie_reg, auto_flow_enable_reg, rts_bit_reg};
        else if (hit(addr_i, ADDR_STAT)) rdata_o <= {11'h000, tx_cnt_reg, 3'h0, rx_cnt_reg,
                                                     tx_state_reg != S_IDLE, match_reg, ovr_reg, ferr_reg,
                                                     perr_reg, rts_n_o, cts_n_i, delta_cts_reg};
      end
    end
  end

  sequence s_tx_launch;
    tx_state_reg == S_IDLE ##1 tx_state_reg == S_START;
  endsequence

  idle_line_high_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    tx_state_reg == S_IDLE ##1 tx_state_reg == S_IDLE |-> txd_o)
    else $error("line not high while idle");
  start_bit_low_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    s_tx_launch ##1 !irda_reg |-> !txd_o)
    else $error("start bit not low");
  lsb_first_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (tx_state_reg == S_DATA && !irda_reg) |=> txd_o == $past(tx_shift_reg[0]))
    else $error("data bit out of order");
  cts_gate_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    s_tx_launch |-> $past(!auto_flow_enable_reg || !cts_n_i))
    else $error("character started while cts high");
  ir_pulse_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    ir_tx_o |-> $past(irda_reg && tx_tick_reg < IR_PULSE_TICKS && !tx_line))
    else $error("infrared pulse outside window");
  rts_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (auto_flow_enable_reg && at_trig) |=> rts_n_o)
    else $error("rts low at trigger");
  rts_release_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (auto_flow_enable_reg && !at_trig) |=> !rts_n_o)
    else $error("rts high below trigger");
  rts_manual_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !auto_flow_enable_reg |=> rts_n_o == $past(rts_bit_reg))
    else $error("rts not following control bit");
  dma_gate_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !fifo_en_reg |=> !dma_rx_req_o && !dma_tx_req_o)
    else $error("dma request without fifo enable");
  tx_dma_req_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (dma_en && tx_cnt_reg != FIFO_DEPTH) |=> dma_tx_req_o)
    else $error("tx dma request missing");
  delta_cts_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (cts_n_i != cts_prev_reg) |=> delta_cts_reg)
    else $error("cts change not flagged");
endmodule
